// *** verilog/lgc_pkg.sv ***
/*
 Package for the general control command decoder: command codes, field positions,
 reset values and timing counts. Assumes a 100 MHz system clock.
*/
package lgc_pkg;

   // Command framing
   localparam logic [1:0] RS_CONTROL = 2'h0;
   localparam logic [7:0] CMD_INIT = 8'h3a;
   localparam logic [7:0] CMD_OTP_REFRESH = 8'hd8;
   localparam logic [7:0] CMD_CLEAR_RESET_FLAG = 8'h1f;
   localparam logic [5:0] CMD_CASCADE_POS_TOP = 6'h06;
   localparam logic [6:0] CMD_SYNC_CFG_TOP = 7'h5c;
   localparam logic [6:0] CMD_CLOCK_OUT_TOP = 7'h6a;
   localparam logic [6:0] CMD_READ_SELECT_TOP = 7'h0e;

   // Cascade positions
   localparam logic [1:0] POS_MASTER = 2'h0;

   // Status byte fields
   localparam int ST_DISPLAY_BIT = 7;
   localparam int ST_PUMP_ON_BIT = 6;
   localparam int ST_PUMP_AT_BIT = 5;
   localparam int ST_RESET_FLAG_BIT = 4;
   localparam logic [1:0] DETECT_I2C_TOP = 2'h1;
   localparam logic [3:0] DETECT_SPI_CODE = 4'h5;

   // Reset values
   localparam logic [1:0] CASCADE_POS_RST = 2'h0;
   localparam logic SYNC_ENABLE_RST = 1'b0;
   localparam logic CLOCK_GATE_RST = 1'b0;
   localparam logic READ_SEL_RST = 1'b0;
   localparam logic RESET_FLAG_RST = 1'b1;

   // Calibration reload time
   localparam int CLK_HZ = 100000000;
   localparam int CAL_RELOAD_MS = 10;
   localparam int CAL_RELOAD_CYCLES = (CLK_HZ / 1000) * CAL_RELOAD_MS;

   typedef struct packed {
      logic valid;
      logic read_not_write;
      logic [1:0] register_select;
      logic [7:0] data;
   } lgc_cmd_type;

   typedef struct packed {
      logic display_on_state;
      logic pump_enable_bit;
      logic pump_at_target;
      logic spi_mode;
      logic bus_addr_pin_hi;
      logic bus_addr_pin_lo;
   } lgc_live_type;

   typedef struct packed {
      logic [1:0] cascade_pos;
      logic sync_enable;
      logic clock_output_gate;
      logic read_sel_status;
   } lgc_cfg_type;

endpackage

// *** verilog/lgc_sync2.sv ***
/*
 Two-flip-flop synchroniser for a bundle of pin levels.
 Assumes the pins are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module lgc_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } lgc_sync_state_type;

   lgc_sync_state_type state_r;
   lgc_sync_state_type state_nxt;

   always_comb begin
      state_nxt.first = pin_in;
      state_nxt.second = state_r.first;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign sync_out = state_r.second;
endmodule

// *** verilog/lgc_ctrl.sv ***
/*
 General control command decoder of a cascadable LCD segment driver: chip reset,
 calibration reload, cascade position, sync pin, clock output gate and status readout.
 Assumes a command front end delivering one decoded byte per valid pulse on clk_sys,
 and that display RAM lives elsewhere and is not touched by the reset issued here.
*/
// What this block does
// RULE_01 - Write, select 00, byte 3a issues a chip reset sparing display RAM
// RULE_02 - Reset pin resets the whole device like the reset command
// RULE_03 - Calibration reloads after any reset, reset command, or refresh command
// RULE_04 - Refresh command byte d8; reload takes about 10 ms
// RULE_05 - Byte 000110xx sets cascade position: master or slave 1 to 3
// RULE_06 - Byte 1011100x: sync pin low or cascade sync output
// RULE_07 - A slave ignores the sync pin command
// RULE_08 - Byte 1101010x: drives clock out or leaves the pin floating
// RULE_09 - Byte 0001110x selects temperature or status for later reads
// RULE_10 - Read with select 00 returns the full temperature byte when chosen
// RULE_11 - Status bits reflect live state at the read instant
// RULE_12 - Status bit 7 shows display enabled
// RULE_13 - Status bit 6 mirrors the pump enable setting
// RULE_14 - Status bit 5 shows pump reached programmed voltage
// RULE_15 - Status bit 4 is a sticky reset flag set by any reset
// RULE_16 - Host should clear the reset flag at start-up
// RULE_17 - Bits 3 to 0 give 01 plus address pins on I2C, 0101 on SPI
// RULE_18 - Host may poll status to detect upset bits
// RULE_19 - Write, select 00, byte 1f clears the sticky reset flag
// RULE_20 - Only bytes with matching direction and select bits are acted on
`timescale 1ns/1ps
module lgc_ctrl #(
   parameter int CAL_CYCLES = lgc_pkg::CAL_RELOAD_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Reset pin, active low, asynchronous
   input wire logic reset_pin_n,
   // Command stream from the bus front end
   input wire lgc_pkg::lgc_cmd_type cmd,
   // Live device state
   input wire lgc_pkg::lgc_live_type live,
   input wire logic [7:0] temperature_value,
   input wire logic cascade_sync_in,
   input wire logic clk_is_output,
   // Read answer
   output logic [7:0] read_data,
   output logic read_valid,
   // Chip-wide control
   output logic chip_reset,
   output logic cal_reload_busy,
   output logic cal_reload_start,
   output lgc_pkg::lgc_cfg_type cfg,
   // Pins
   output logic cascade_sync_pin,
   output logic clk_out,
   output logic clk_out_oe
);
   import lgc_pkg::*;

   typedef struct packed {
      lgc_cfg_type cfg;
      logic reset_flag;
      logic chip_reset;
      logic cal_start;
      logic cal_busy;
      logic [31:0] cal_count;
      logic [7:0] read_data;
      logic read_valid;
      logic reset_seen;
   } lgc_state_type;

   lgc_state_type state_r;
   lgc_state_type state_nxt;

   logic [6:0] pins_sync;
   lgc_live_type live_s;
   logic reset_pin_s_n;

   // Pin levels cross into clk_sys before use; the reset pin goes in inverted so that
   // the cleared synchroniser means no request and no false reset follows rstn release
   lgc_sync2 #(.WIDTH(7)) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pin_in({~reset_pin_n, live.display_on_state, live.pump_at_target, live.spi_mode,
               live.bus_addr_pin_hi, live.bus_addr_pin_lo, cascade_sync_in}),
      .sync_out(pins_sync)
   );

   function automatic logic ctrl_write(input lgc_cmd_type c);
      ctrl_write = c.valid && !c.read_not_write && (c.register_select == RS_CONTROL);
   endfunction

   function automatic logic [7:0] status_byte(input lgc_live_type l, input logic flag);
      logic [7:0] s;
      s = 8'h00;
      s[ST_DISPLAY_BIT] = l.display_on_state;
      s[ST_PUMP_ON_BIT] = l.pump_enable_bit;
      s[ST_PUMP_AT_BIT] = l.pump_at_target;
      s[ST_RESET_FLAG_BIT] = flag;
      s[3:0] = l.spi_mode ? DETECT_SPI_CODE : {DETECT_I2C_TOP, l.bus_addr_pin_hi, l.bus_addr_pin_lo};
      status_byte = s;
   endfunction

   always_comb begin
      live_s.display_on_state = pins_sync[5];
      live_s.pump_enable_bit = live.pump_enable_bit;
      live_s.pump_at_target = pins_sync[4];
      live_s.spi_mode = pins_sync[3];
      live_s.bus_addr_pin_hi = pins_sync[2];
      live_s.bus_addr_pin_lo = pins_sync[1];
      reset_pin_s_n = ~pins_sync[6];
   end

   always_comb begin
      logic wr;
      logic do_reset;
      logic do_refresh;
      logic do_clear;
      wr = ctrl_write(cmd); // RULE_20
      do_reset = (wr && cmd.data == CMD_INIT) || !reset_pin_s_n; // RULE_01 RULE_02
      do_refresh = wr && cmd.data == CMD_OTP_REFRESH;
      do_clear = wr && cmd.data == CMD_CLEAR_RESET_FLAG;
      state_nxt = state_r;
      state_nxt.chip_reset = do_reset;
      state_nxt.cal_start = 1'b0;
      state_nxt.read_valid = 1'b0;
      state_nxt.reset_seen = 1'b1;
      if (do_reset) begin
         // Configuration returns to defaults; display RAM is not ours
         state_nxt.cfg.cascade_pos = CASCADE_POS_RST; // RULE_01
         state_nxt.cfg.sync_enable = SYNC_ENABLE_RST;
         state_nxt.cfg.clock_output_gate = CLOCK_GATE_RST;
         state_nxt.cfg.read_sel_status = READ_SEL_RST;
      end else if (wr) begin
         if (cmd.data[7:2] == CMD_CASCADE_POS_TOP) begin
            state_nxt.cfg.cascade_pos = cmd.data[1:0]; // RULE_05
         end
         if (cmd.data[7:1] == CMD_SYNC_CFG_TOP && state_r.cfg.cascade_pos == POS_MASTER) begin
            state_nxt.cfg.sync_enable = cmd.data[0]; // RULE_06 RULE_07
         end
         if (cmd.data[7:1] == CMD_CLOCK_OUT_TOP) begin
            state_nxt.cfg.clock_output_gate = cmd.data[0]; // RULE_08
         end
         if (cmd.data[7:1] == CMD_READ_SELECT_TOP) begin
            state_nxt.cfg.read_sel_status = cmd.data[0]; // RULE_09
         end
      end
      // Set wins over clear; reset release counts as a power-on event
      if (do_clear) begin
         state_nxt.reset_flag = 1'b0; // RULE_19
      end
      if (do_reset || !state_r.reset_seen) begin
         state_nxt.reset_flag = 1'b1; // RULE_15
      end
      // Calibration reload restarts on any reset or refresh
      if (do_reset || do_refresh || !state_r.reset_seen) begin
         state_nxt.cal_start = 1'b1; // RULE_03
         state_nxt.cal_busy = 1'b1;
         state_nxt.cal_count = 32'(CAL_CYCLES - 1); // RULE_04
      end else if (state_r.cal_busy) begin
         if (state_r.cal_count == 32'h0) begin
            state_nxt.cal_busy = 1'b0;
         end else begin
            state_nxt.cal_count = state_r.cal_count - 32'h1;
         end
      end
      if (cmd.valid && cmd.read_not_write && cmd.register_select == RS_CONTROL) begin
         state_nxt.read_valid = 1'b1; // RULE_10
         state_nxt.read_data = state_r.cfg.read_sel_status
            ? status_byte(live_s, state_r.reset_flag) // RULE_11 RULE_12 RULE_13 RULE_14 RULE_17
            : temperature_value; // RULE_10
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_r.cfg.cascade_pos <= CASCADE_POS_RST;
         state_r.cfg.sync_enable <= SYNC_ENABLE_RST;
         state_r.cfg.clock_output_gate <= CLOCK_GATE_RST;
         state_r.cfg.read_sel_status <= READ_SEL_RST;
         state_r.reset_flag <= RESET_FLAG_RST;
         state_r.chip_reset <= 1'b0;
         state_r.cal_start <= 1'b0;
         state_r.cal_busy <= 1'b1;
         state_r.cal_count <= 32'h0;
         state_r.read_data <= 8'h00;
         state_r.read_valid <= 1'b0;
         state_r.reset_seen <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign read_data = state_r.read_data;
   assign read_valid = state_r.read_valid;
   assign chip_reset = state_r.chip_reset;
   assign cal_reload_start = state_r.cal_start;
   assign cal_reload_busy = state_r.cal_busy;
   assign cfg = state_r.cfg;
   // Sync disabled holds the sync pin low; sync enabled forwards the cascade sync
   assign cascade_sync_pin = state_r.cfg.sync_enable & pins_sync[0]; // RULE_06
   assign clk_out = clk_sys;
   assign clk_out_oe = clk_is_output & state_r.cfg.clock_output_gate; // RULE_08
endmodule

// *** tb/lgc_ctrl_asserts.sv ***
/*
 Concurrent checks on the ports of the general control command decoder.
 Assumes one clock, clk_sys, and the active-low asynchronous reset rstn.
*/
`timescale 1ns/1ps
module lgc_ctrl_asserts #(
   parameter int CAL_CYCLES = 20
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Inputs
   input wire logic reset_pin_n,
   input wire lgc_pkg::lgc_cmd_type cmd,
   input wire logic clk_is_output,
   // Outputs
   input wire logic read_valid,
   input wire logic chip_reset,
   input wire logic cal_reload_busy,
   input wire logic cal_reload_start,
   input wire lgc_pkg::lgc_cfg_type cfg,
   input wire logic clk_out_oe
);
   import lgc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic wr_ok;
   logic init_cmd;
   assign wr_ok = cmd.valid && !cmd.read_not_write && cmd.register_select == 2'h0;
   assign init_cmd = wr_ok && cmd.data == 8'h3a;
   read_answer_a: assert property (cmd.valid && cmd.read_not_write && cmd.register_select == 2'h0 |=> read_valid)
      else $error("read not answered");
   read_ignore_a: assert property (!(cmd.valid && cmd.read_not_write && cmd.register_select == 2'h0) |=> !read_valid)
      else $error("unmatched read answered");
   init_reset_a: assert property (wr_ok && cmd.data == 8'h3a |=> chip_reset && cal_reload_start && cfg == '0)
      else $error("reset command without reset");
   refresh_start_a: assert property (wr_ok && cmd.data == 8'hd8 |=> cal_reload_start ##1 cal_reload_busy[*8])
      else $error("refresh did not start reload");
   cascade_pos_a: assert property (wr_ok && cmd.data[7:2] == 6'h06 |=> cfg.cascade_pos == $past(cmd.data[1:0]))
      else $error("cascade position not taken");
   slave_sync_a: assert property (wr_ok && cmd.data[7:1] == 7'h5c && cfg.cascade_pos != 2'h0 |=> $stable(cfg.sync_enable))
      else $error("slave took sync command");
   clock_gate_a: assert property (clk_out_oe == (clk_is_output && cfg.clock_output_gate))
      else $error("clock pin enable wrong");
   read_sel_a: assert property (wr_ok && cmd.data[7:1] == 7'h0e |=> cfg.read_sel_status == $past(cmd.data[0]))
      else $error("readout select not taken");
   reset_cause_a: assert property (chip_reset |-> !$past(reset_pin_n, 3) || $past(init_cmd))
      else $error("chip reset without pin or command");
   cover property (chip_reset && !reset_pin_n);
   cover property (read_valid && cfg.read_sel_status);
   cover property (cfg.sync_enable);
endmodule
bind lgc_ctrl lgc_ctrl_asserts #(.CAL_CYCLES(CAL_CYCLES)) i_lgc_ctrl_asserts (.clk_sys(clk_sys), .rstn(rstn),
   .reset_pin_n(reset_pin_n), .cmd(cmd), .clk_is_output(clk_is_output), .read_valid(read_valid),
   .chip_reset(chip_reset), .cal_reload_busy(cal_reload_busy), .cal_reload_start(cal_reload_start),
   .cfg(cfg), .clk_out_oe(clk_out_oe));

// *** tb/lgc_host_model.sv ***
/*
 Host side: sends one command byte per call as a one-cycle valid.
 Assumes the decoder samples on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
module lgc_host_model (
   // Clock
   input wire logic clk_sys,
   // Command stream
   output lgc_pkg::lgc_cmd_type cmd
);
   import lgc_pkg::*;
   initial cmd = '0;
   // Released fields carry the inverse so stale data is never mistaken
   task automatic send(input logic rnw, input logic [1:0] rs, input logic [7:0] d);
      @(negedge clk_sys);
      cmd = '{1'b1, rnw, rs, d};
      @(negedge clk_sys);
      cmd = '{1'b0, ~rnw, ~rs, ~d};
   endtask
endmodule

// *** tb/test_lgc_ctrl.sv ***
/*
 Testbench for the general control command decoder.
 Assumes the host model drives commands; live inputs are driven here on the falling edge.
*/
`timescale 1ns/1ps
module test_lgc_ctrl;
   import lgc_pkg::*;
   logic clk_sys, rstn, reset_pin_n, cascade_sync_in, clk_is_output, read_valid, chip_reset;
   logic cal_reload_busy, cal_reload_start, cascade_sync_pin, clk_out, clk_out_oe;
   lgc_cmd_type cmd;
   lgc_live_type live;
   lgc_cfg_type cfg;
   logic [7:0] temperature_value, read_data;
   int errors = 0;
   int n_checks = 0;
   lgc_host_model i_lgc_host_model (.clk_sys(clk_sys), .cmd(cmd));
   lgc_ctrl #(.CAL_CYCLES(20)) i_lgc_ctrl (.clk_sys(clk_sys), .rstn(rstn), .reset_pin_n(reset_pin_n), .cmd(cmd),
      .live(live), .temperature_value(temperature_value), .cascade_sync_in(cascade_sync_in),
      .clk_is_output(clk_is_output), .read_data(read_data), .read_valid(read_valid), .chip_reset(chip_reset),
      .cal_reload_busy(cal_reload_busy), .cal_reload_start(cal_reload_start), .cfg(cfg),
      .cascade_sync_pin(cascade_sync_pin), .clk_out(clk_out), .clk_out_oe(clk_out_oe));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      i_lgc_host_model.send(1'b0, 2'h0, d);
   endtask
   task automatic rd(input logic [7:0] exp);
      i_lgc_host_model.send(1'b1, 2'h0, 8'h00);
      chk("read_valid", {7'h0, read_valid}, 8'h01);
      chk("read_data", read_data, exp);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic t_status();
      wr(8'h1d);
      rd(8'hd5);
      wr(8'h1f);
      rd(8'hc5);
      live = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      repeat (4) @(negedge clk_sys);
      rd(8'h26);
   endtask
   task automatic t_init();
      wr(8'h3a);
      chk("chip_reset", {7'h0, chip_reset}, 8'h01);
      chk("busy", {7'h0, cal_reload_busy}, 8'h01);
      rd(8'ha5);
      wr(8'h1f);
      reset_pin_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("pin reset", {7'h0, chip_reset}, 8'h01);
      reset_pin_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      wr(8'h1d);
      rd(8'h36);
   endtask
   task automatic t_cascade();
      for (int p = 0; p < 4; p++) begin
         wr({6'h06, p[1:0]});
         chk("position", {6'h0, cfg.cascade_pos}, {6'h0, p[1:0]});
      end
      wr(8'hb9);
      chk("slave sync", {7'h0, cfg.sync_enable}, 8'h00);
      wr(8'h18);
      wr(8'hb9);
      cascade_sync_in = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk("sync pin", {7'h0, cascade_sync_pin}, 8'h01);
      wr(8'hb8);
      chk("sync low", {7'h0, cascade_sync_pin}, 8'h00);
   endtask
   task automatic t_misc();
      clk_is_output = 1'b1;
      wr(8'hd5);
      chk("clk oe on", {7'h0, clk_out_oe}, 8'h01);
      chk("clk out low", {7'h0, clk_out}, 8'h00);
      @(posedge clk_sys);
      #1;
      chk("clk out high", {7'h0, clk_out}, 8'h01);
      @(negedge clk_sys);
      wr(8'hd4);
      chk("clk oe off", {7'h0, clk_out_oe}, 8'h00);
      i_lgc_host_model.send(1'b1, 2'h1, 8'h00);
      chk("bad read", {7'h0, read_valid}, 8'h00);
      i_lgc_host_model.send(1'b0, 2'h2, 8'h3a);
      chk("bad init", {7'h0, chip_reset}, 8'h00);
      repeat (30) @(negedge clk_sys);
      wr(8'hd8);
      repeat (15) @(negedge clk_sys);
      chk("reload busy", {7'h0, cal_reload_busy}, 8'h01);
      repeat (10) @(negedge clk_sys);
      chk("reload done", {7'h0, cal_reload_busy}, 8'h00);
   endtask
   initial begin
      #50us;
      errors++;
      give_verdict();
   end
   initial begin
      rstn = 1'b0;
      reset_pin_n = 1'b1;
      cascade_sync_in = 1'b0;
      clk_is_output = 1'b0;
      temperature_value = 8'ha5;
      live = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      repeat (16) @(negedge clk_sys);
      rstn = 1'b1;
      t_status();
      t_init();
      t_cascade();
      t_misc();
      give_verdict();
   end
endmodule
